// [pkg/ctu_pkg.sv]
package ctu_pkg;

  // Bus geometry
  localparam int unsigned CTU_ADR_W = 8;
  localparam int unsigned CTU_DAT_W = 32;
  localparam int unsigned CTU_SEL_W = 4;
  localparam int unsigned CTU_LANE_W = 8;
  localparam int unsigned CTU_CHAN_W = 5;
  localparam int unsigned CTU_CNT_W = 32;

  // Register byte offsets
  localparam logic [7:0] CTU_OFS_CTRL = 8'h00;
  localparam logic [7:0] CTU_OFS_EDGE = 8'h04;
  localparam logic [7:0] CTU_OFS_CHAN = 8'h08;
  localparam logic [7:0] CTU_OFS_STAT = 8'h0c;
  localparam logic [7:0] CTU_OFS_COUNT = 8'h10;

  // Control register fields
  localparam int unsigned CTU_BIT_ON = 15;
  localparam int unsigned CTU_BIT_SIDL = 5;
  localparam int unsigned CTU_BIT_DISCH = 1;

  // Edge register fields
  localparam int unsigned CTU_BIT_EDGE1 = 0;
  localparam int unsigned CTU_BIT_EDGE2 = 1;

  // Status register fields; corrupt flag is write-one-to-clear
  localparam int unsigned CTU_ST_SRC = 0;
  localparam int unsigned CTU_ST_DIS = 1;
  localparam int unsigned CTU_ST_CORRUPT = 2;
  localparam int unsigned CTU_ST_SLEEP = 3;
  localparam int unsigned CTU_ST_IDLE = 4;
  localparam int unsigned CTU_ST_TEMP = 5;
  localparam int unsigned CTU_ST_HOLD = 6;
  localparam int unsigned CTU_ST_GATED = 7;

  // Fixed channel of the on-chip temperature diode
  localparam logic [4:0] CTU_TEMP_CHAN = 5'h1d;

  // Word constants: zero, count step and count ceiling
  localparam logic [31:0] CTU_WORD_ZERO = 32'h0000_0000;
  localparam logic [31:0] CTU_CNT_ONE = 32'h0000_0001;
  localparam logic [31:0] CTU_CNT_MAX = 32'hffff_ffff;

  typedef enum logic [2:0] {
    CTU_M_OFF,
    CTU_M_READY,
    CTU_M_CHARGE,
    CTU_M_HOLD,
    CTU_M_GATED,
    CTU_M_DRAIN
  } ctu_mode_e;

  // Analog side controls towards the shared multiplexer
  typedef struct packed {
    logic source_on;
    logic discharge;
    logic temp_diode_sel;
    logic [4:0] chan;
  } ctu_analog_s;

  typedef struct packed {
    logic module_on;
    logic stop_in_idle;
    logic discharge;
    logic first_edge;
    logic second_edge;
    logic [4:0] chan;
    logic corrupt;
    logic start;
    logic ack;
    logic [31:0] rdata;
    ctu_mode_e mode;
    ctu_analog_s analog;
  } ctu_state_s;

  typedef struct packed {
    logic [31:0] count;
  } ctu_timer_s;

  localparam ctu_state_s CTU_STATE_RST = '0;
  localparam ctu_timer_s CTU_TIMER_RST = '0;

endpackage : ctu_pkg

// [logic/ctu_interval_timer.sv]
`timescale 1ns/1ps
module ctu_interval_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic run_i,
  output logic [31:0] count_o
);

  ctu_pkg::ctu_timer_s st_reg;
  ctu_pkg::ctu_timer_s st_next;

  // Count cycles with the source on; saturate rather than wrap
  always_comb begin
    st_next = st_reg;
    if (clear_i) begin
      // Start of a measurement discards the old figure
      st_next.count = run_i ? ctu_pkg::CTU_CNT_ONE : ctu_pkg::CTU_WORD_ZERO;
    end else if (run_i && (st_reg.count != ctu_pkg::CTU_CNT_MAX)) begin
      st_next.count = st_reg.count + ctu_pkg::CTU_CNT_ONE;
    end
  end

  // Reset drops any partial result
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= ctu_pkg::CTU_TIMER_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign count_o = st_reg.count;

endmodule : ctu_interval_timer

// [logic/ctu_charge_time_ctrl.sv]
`timescale 1ns/1ps
module ctu_charge_time_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sleep_i,
  input wire logic idle_i,
  output ctu_pkg::ctu_analog_s analog_o
);

  ctu_pkg::ctu_state_s st_reg;
  ctu_pkg::ctu_state_s st_next;
  logic [31:0] count;
  logic access;
  logic wr;
  logic gated;

  // Byte-lane mask from the Wishbone select lines
  function automatic logic [31:0] ctu_lane_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = ctu_pkg::CTU_WORD_ZERO;
    for (int i = 0; i < ctu_pkg::CTU_SEL_W; i++) begin
      m[i*ctu_pkg::CTU_LANE_W +: ctu_pkg::CTU_LANE_W] = {ctu_pkg::CTU_LANE_W{sel[i]}};
    end
    return m;
  endfunction : ctu_lane_mask

  // Old word with the selected lanes replaced
  function automatic logic [31:0] ctu_merge(input logic [31:0] old, input logic [31:0] wdat,
                                            input logic [3:0] sel);
    logic [31:0] m;
    m = ctu_lane_mask(sel);
    return (old & ~m) | (wdat & m);
  endfunction : ctu_merge

  // Software view of the control register
  function automatic logic [31:0] ctu_ctrl_word(input ctu_pkg::ctu_state_s s);
    logic [31:0] w;
    w = ctu_pkg::CTU_WORD_ZERO;
    w[ctu_pkg::CTU_BIT_ON] = s.module_on;
    w[ctu_pkg::CTU_BIT_SIDL] = s.stop_in_idle;
    w[ctu_pkg::CTU_BIT_DISCH] = s.discharge;
    return w;
  endfunction : ctu_ctrl_word

  // Software view of the edge register
  function automatic logic [31:0] ctu_edge_word(input ctu_pkg::ctu_state_s s);
    logic [31:0] w;
    w = ctu_pkg::CTU_WORD_ZERO;
    w[ctu_pkg::CTU_BIT_EDGE1] = s.first_edge;
    w[ctu_pkg::CTU_BIT_EDGE2] = s.second_edge;
    return w;
  endfunction : ctu_edge_word

  // Software view of the channel register
  function automatic logic [31:0] ctu_chan_word(input ctu_pkg::ctu_state_s s);
    logic [31:0] w;
    w = ctu_pkg::CTU_WORD_ZERO;
    w[ctu_pkg::CTU_CHAN_W-1:0] = s.chan;
    return w;
  endfunction : ctu_chan_word

  // Live status; power inputs are shown as seen this cycle
  function automatic logic [31:0] ctu_stat_word(input ctu_pkg::ctu_state_s s, input logic slp,
                                                input logic idl);
    logic [31:0] w;
    w = ctu_pkg::CTU_WORD_ZERO;
    w[ctu_pkg::CTU_ST_SRC] = s.analog.source_on;
    w[ctu_pkg::CTU_ST_DIS] = s.analog.discharge;
    w[ctu_pkg::CTU_ST_CORRUPT] = s.corrupt;
    w[ctu_pkg::CTU_ST_SLEEP] = slp;
    w[ctu_pkg::CTU_ST_IDLE] = idl;
    w[ctu_pkg::CTU_ST_TEMP] = s.analog.temp_diode_sel;
    w[ctu_pkg::CTU_ST_HOLD] = (s.mode == ctu_pkg::CTU_M_HOLD);
    w[ctu_pkg::CTU_ST_GATED] = (s.mode == ctu_pkg::CTU_M_GATED);
    return w;
  endfunction : ctu_stat_word

  // Read mux; unmapped offsets read as zero
  function automatic logic [31:0] ctu_read(input logic [7:0] adr, input ctu_pkg::ctu_state_s s,
                                           input logic [31:0] cnt, input logic slp, input logic idl);
    logic [31:0] w;
    w = ctu_pkg::CTU_WORD_ZERO;
    unique case (adr)
      ctu_pkg::CTU_OFS_CTRL: w = ctu_ctrl_word(s);
      ctu_pkg::CTU_OFS_EDGE: w = ctu_edge_word(s);
      ctu_pkg::CTU_OFS_CHAN: w = ctu_chan_word(s);
      ctu_pkg::CTU_OFS_STAT: w = ctu_stat_word(s, slp, idl);
      ctu_pkg::CTU_OFS_COUNT: w = cnt;
      default: w = ctu_pkg::CTU_WORD_ZERO;
    endcase
    return w;
  endfunction : ctu_read

  // One access per request; the ack cycle itself is never a new access
  assign access = wb_cyc_i && wb_stb_i && !st_reg.ack;
  assign wr = access && wb_we_i;

  // Power gating: Sleep always, Idle only when stop-in-idle is set
  assign gated = sleep_i || (idle_i && st_reg.stop_in_idle);

  // Next state: bus writes first, then hardware decisions on the new bits, except the idle gate, which reads the old stop-in-idle bit
  always_comb begin
    logic [31:0] w;
    w = ctu_pkg::CTU_WORD_ZERO;
    st_next = st_reg;
    st_next.ack = access;
    st_next.start = 1'b0;
    if (access) begin
      st_next.rdata = ctu_read(wb_adr_i, st_reg, count, sleep_i, idle_i);
    end
    if (wr) begin
      unique case (wb_adr_i)
        ctu_pkg::CTU_OFS_CTRL: begin
          w = ctu_merge(ctu_ctrl_word(st_reg), wb_dat_i, wb_sel_i);
          st_next.module_on = w[ctu_pkg::CTU_BIT_ON];
          st_next.stop_in_idle = w[ctu_pkg::CTU_BIT_SIDL];
          st_next.discharge = w[ctu_pkg::CTU_BIT_DISCH];
        end
        ctu_pkg::CTU_OFS_EDGE: begin
          w = ctu_merge(ctu_edge_word(st_reg), wb_dat_i, wb_sel_i);
          st_next.first_edge = w[ctu_pkg::CTU_BIT_EDGE1];
          st_next.second_edge = w[ctu_pkg::CTU_BIT_EDGE2];
        end
        ctu_pkg::CTU_OFS_CHAN: begin
          w = ctu_merge(ctu_chan_word(st_reg), wb_dat_i, wb_sel_i);
          st_next.chan = w[ctu_pkg::CTU_CHAN_W-1:0];
        end
        ctu_pkg::CTU_OFS_STAT: begin
          // Write one to clear; only the corrupt flag is writable
          w = wb_dat_i & ctu_lane_mask(wb_sel_i);
          if (w[ctu_pkg::CTU_ST_CORRUPT]) begin
            st_next.corrupt = 1'b0;
          end
        end
        default: begin
          // Count and unmapped offsets ignore writes but still ack
          w = ctu_pkg::CTU_WORD_ZERO;
        end
      endcase
    end

    // A new first edge restarts the interval figure
    st_next.start = st_next.first_edge && !st_reg.first_edge && st_next.module_on;

    // Charging cut short by power gating spoils the result; set beats clear
    if ((st_reg.mode == ctu_pkg::CTU_M_CHARGE) && gated) begin
      st_next.corrupt = 1'b1;
    end

    // Mode choice; disable and drain outrank everything else
    if (!st_next.module_on) begin
      st_next.mode = ctu_pkg::CTU_M_OFF;
    end else if (st_next.discharge) begin
      st_next.mode = ctu_pkg::CTU_M_DRAIN;
    end else if (gated) begin
      st_next.mode = ctu_pkg::CTU_M_GATED;
    end else if (st_next.first_edge && !st_next.second_edge) begin
      st_next.mode = ctu_pkg::CTU_M_CHARGE;
    end else if (st_next.first_edge && st_next.second_edge) begin
      st_next.mode = ctu_pkg::CTU_M_HOLD;
    end else begin
      st_next.mode = ctu_pkg::CTU_M_READY;
    end

    // Analog drive from the chosen mode; source and ground never together
    st_next.analog.source_on = 1'b0;
    st_next.analog.discharge = 1'b0;
    unique case (st_next.mode)
      ctu_pkg::CTU_M_CHARGE: st_next.analog.source_on = 1'b1;
      ctu_pkg::CTU_M_DRAIN: st_next.analog.discharge = 1'b1;
      ctu_pkg::CTU_M_OFF,
      ctu_pkg::CTU_M_READY,
      ctu_pkg::CTU_M_HOLD,
      ctu_pkg::CTU_M_GATED: st_next.analog.source_on = 1'b0;
      default: st_next.analog.source_on = 1'b0;
    endcase

    // Channel goes to the converter's multiplexer whether or not the unit is on
    st_next.analog.chan = st_next.chan;
    st_next.analog.temp_diode_sel = (st_next.chan == ctu_pkg::CTU_TEMP_CHAN);
  end

  // Single state register; reset clears every field
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= ctu_pkg::CTU_STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Interval counter runs only while the source is really on
  ctu_interval_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(st_reg.start),
    .run_i(st_reg.analog.source_on),
    .count_o(count)
  );

  // Outputs straight from the state register
  assign wb_ack_o = st_reg.ack;
  assign wb_dat_o = st_reg.rdata;
  assign analog_o = st_reg.analog;

endmodule : ctu_charge_time_ctrl

// [tb/ctu_charge_time_ctrl_asserts.sv]
`timescale 1ns/1ps
module ctu_charge_time_ctrl_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic sleep_i,
  input wire logic idle_i,
  input wire ctu_pkg::ctu_analog_s analog_o
);
  logic on_reg, sidl_reg, dis_reg, e1_reg, e2_reg;
  logic [4:0] chan_reg;
  logic wr;
  // Shadow of written control bits; lands on the edge that takes the write
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {on_reg, sidl_reg, dis_reg, e1_reg, e2_reg, chan_reg} <= '0;
    end else if (wr && wb_sel_i[0]) begin
      if (wb_adr_i == 8'h00) {sidl_reg, dis_reg} <= {wb_dat_i[5], wb_dat_i[1]};
      if (wb_adr_i == 8'h04) {e2_reg, e1_reg} <= wb_dat_i[1:0];
      if (wb_adr_i == 8'h08) chan_reg <= wb_dat_i[4:0];
    end
    if (!rst_i && wr && wb_sel_i[1] && wb_adr_i == 8'h00) on_reg <= wb_dat_i[15];
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_pulse: assert property (s_take |=> s_pulse) else $error("ack not a single pulse");
  // Power gating seen one edge late, as the analog outputs are registered
  a_sleep_off: assert property ($past(sleep_i) |-> !analog_o.source_on)
    else $error("source on during sleep");
  // Gate reads the stop-in-idle bit as it stood before the edge
  a_idle_stop: assert property ($past(idle_i) && $past(sidl_reg) |-> !analog_o.source_on)
    else $error("source on in idle with stop set");
  a_charge_edges: assert property (on_reg && !dis_reg && !$past(sleep_i)
    && !($past(idle_i) && $past(sidl_reg)) |-> analog_o.source_on == (e1_reg && !e2_reg))
    else $error("source does not follow edge bits");
  a_off_inert: assert property (!on_reg |-> !analog_o.source_on && !analog_o.discharge)
    else $error("node driven while off");
  a_node_ground: assert property (analog_o.discharge == (on_reg && dis_reg)
    && !(analog_o.discharge && analog_o.source_on)) else $error("discharge wrong");
  a_chan_shared: assert property (analog_o.chan == chan_reg) else $error("channel mismatch");
  a_temp_chan: assert property (analog_o.temp_diode_sel == (analog_o.chan == ctu_pkg::CTU_TEMP_CHAN))
    else $error("diode flag wrong");
  a_reset_clear: assert property ($past(rst_i) |-> analog_o == '0 && !wb_ack_o && wb_dat_o == '0)
    else $error("outputs not clear after reset");
endmodule : ctu_charge_time_ctrl_asserts

bind ctu_charge_time_ctrl ctu_charge_time_ctrl_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .sleep_i(sleep_i), .idle_i(idle_i), .analog_o(analog_o));

// [tb/ctu_adc_model.sv]
`timescale 1ns/1ps
module ctu_adc_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire ctu_pkg::ctu_analog_s analog_i,
  input wire logic start_i,
  output logic [31:0] result_o,
  output logic [4:0] result_chan_o
);
  logic [31:0] node_reg;
  // Node keeps its charge over reset; only grounding empties it
  always_ff @(posedge clk_i) begin
    if (analog_i.discharge) node_reg <= '0;
    else if (analog_i.source_on) node_reg <= node_reg + 32'h1;
    if (rst_i) begin
      {result_o, result_chan_o} <= '0;
    end else if (start_i) begin
      {result_o, result_chan_o} <= {node_reg, analog_i.chan};
    end
  end
endmodule : ctu_adc_model

// [tb/ctu_charge_time_ctrl_test.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
  total_checks++; \
  if ((got) !== (ex)) begin \
    errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
  end end
module ctu_charge_time_ctrl_test;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic sleep = 1'b0, idle = 1'b0, start = 1'b0, ack;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat, res, c;
  logic [4:0] rch;
  ctu_pkg::ctu_analog_s an;
  logic [31:0] q[$];
  int errors = 0, total_checks = 0, seed = 66507;
  always #2 clk_i = ~clk_i;
  ctu_charge_time_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .sleep_i(sleep), .idle_i(idle), .analog_o(an));
  ctu_adc_model u_adc (.clk_i(clk_i), .rst_i(rst_i), .analog_i(an), .start_i(start),
    .result_o(res), .result_chan_o(rch));
  // Classic cycle: hold everything until ack is sampled, then drop
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    wb(1'b0, a, 32'h0, 4'hf);
  endtask : rd
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // Read answers are matched in order against the noted values
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0 && q.size() > 0) begin
      c = q.pop_front();
      `CHK("read data", c, rdat)
    end
  end
  // Watchdog, far beyond the hundred or so cycles the run needs
  initial begin
    #(4 * 20000);
    errors++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) rd(8'(i * 4), 32'h0);
    wr(8'h00, 32'h2);
    wr(8'h04, 32'h1);
    `CHK("off", 2'b00, {an.source_on, an.discharge})
    // Lane 0 masked, so the drain bit written while off survives the enable
    wb(1'b1, 8'h00, 32'h8002, 4'he);
    `CHK("lane merge", 2'b01, {an.source_on, an.discharge})
    wr(8'h00, 32'h8000);
    `CHK("edge on", 2'b10, {an.source_on, an.discharge})
    wr(8'h04, 32'h0);
    `CHK("edge clear", 2'b00, {an.source_on, an.discharge})
    repeat (4) begin
      c = $random(seed);
      wr(8'h08, c);
      `CHK("chan", c[4:0], an.chan)
      `CHK("diode", c[4:0] == 5'h1d, an.temp_diode_sel)
    end
    // Diode channel first, then drain, charge between edges, convert
    wr(8'h08, 32'h1d);
    `CHK("diode", 1'b1, an.temp_diode_sel)
    wr(8'h00, 32'h8002);
    `CHK("drain", 2'b01, {an.source_on, an.discharge})
    wr(8'h00, 32'h8000);
    `CHK("drain end", 2'b00, {an.source_on, an.discharge})
    wr(8'h04, 32'h1);
    repeat (5) @(posedge clk_i);
    wr(8'h04, 32'h3);
    `CHK("second edge", 1'b0, an.source_on)
    @(posedge clk_i) start <= 1'b1;
    @(posedge clk_i) start <= 1'b0;
    @(posedge clk_i);
    `CHK("charge", 32'd8, res)
    `CHK("conv chan", 5'h1d, rch)
    rd(8'h10, 32'd8);
    rd(8'h04, 32'h3);
    wr(8'h04, 32'h1);
    @(posedge clk_i) sleep <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK("sleep", 1'b0, an.source_on)
    sleep <= 1'b0;
    idle <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK("idle run", 1'b1, an.source_on)
    wr(8'h00, 32'h8020);
    // Stop-in-idle gates the source one edge after the write lands
    @(posedge clk_i);
    `CHK("idle stop", 1'b0, an.source_on)
    @(posedge clk_i) idle <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK("resume", 1'b1, an.source_on)
    // Gating a charge left the corrupt flag up; writing one clears it
    rd(8'h0c, 32'h25);
    wr(8'h0c, 32'h4);
    rd(8'h0c, 32'h21);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK("reset", 8'h00, an)
    rd(8'h00, 32'h0);
    rd(8'h10, 32'h0);
    summarize();
  end
endmodule : ctu_charge_time_ctrl_test
